// ### logic/port_io_pkg.sv
`default_nettype none
package port_io_pkg;
  localparam int PORT_W = 8;
  localparam int NUM_PORTS = 4;
  localparam logic [1:0] PORT_A = 2'h0;
  localparam logic [1:0] PORT_B = 2'h1;
  localparam logic [1:0] PORT_C = 2'h2;
  localparam logic [1:0] PORT_D = 2'h3;
  localparam logic [3:0] OFS_DATA_IN = 4'h0;
  localparam logic [3:0] OFS_CONTROL = 4'h1;
  localparam logic [3:0] OFS_DATA_OUT = 4'h2;
  localparam logic [3:0] OFS_DIRECTION = 4'h3;
  localparam logic [3:0] OFS_DRIVE = 4'h4;
  localparam logic [3:0] OFS_INPUT_CELLS = 4'h5;
  localparam logic [3:0] OFS_ENABLE_STATE = 4'h6;
  localparam logic [3:0] OFS_OUTPUT_CELLS = 4'h8;
  localparam logic [3:0] OFS_LOAD_BLOCK = 4'h9;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] ALL_PINS = 8'hff;
  localparam logic [3:0][7:0] PORT_VALID = {8'h06, 8'hff, 8'hff, 8'hff};
  localparam logic [3:0][7:0] OD_MASK = {8'h00, 8'hff, 8'hf0, 8'hf0};
  localparam logic [3:0][7:0] SLEW_MASK = {8'h06, 8'h00, 8'h0f, 8'h0f};
  localparam logic [3:0] HAS_CONTROL = 4'h3;
  localparam int CLOCK_PIN_BIT = 1;
  localparam int SELECT_PIN_BIT = 2;
  localparam int BATTERY_PIN_BIT = 4;
  localparam int SELECT_LSB = 1;
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [5:0] addr;
    logic [7:0] wdata;
  } mcu_req_type;
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe_n;
    logic [7:0] open_drain;
    logic [7:0] fast_slew;
  } pad_drive_type;
  typedef struct packed {
    logic [7:0] oe_pt;
    logic [7:0] use_logic;
  } pld_pin_type;
endpackage
`default_nettype wire

// ### logic/port_lane.sv
`default_nettype none
module port_lane #(
  parameter logic [7:0] VALID = 8'hff,
  parameter logic [7:0] ODM   = 8'h00,
  parameter logic [7:0] SLEWM = 8'h00,
  parameter bit         HASC  = 1'b0
) (
  input  wire logic                       clk_sys,
  input  wire logic                       rst_n,
  input  wire logic                       wr_dout,
  input  wire logic                       wr_dir,
  input  wire logic                       wr_ctrl,
  input  wire logic                       wr_drive,
  input  wire logic [7:0]                 wdata,
  input  wire logic [7:0]                 addr_low,
  input  wire logic [7:0]                 logic_val,
  input  wire logic [7:0]                 logic_use,
  input  wire logic [7:0]                 oe_pt,
  input  wire logic [7:0]                 special_sel,
  input  wire logic [7:0]                 special_val,
  input  wire logic [7:0]                 special_oe,
  output logic [7:0]                      dout_ff,
  output logic [7:0]                      dir_ff,
  output logic [7:0]                      ctrl_ff,
  output logic [7:0]                      drive_ff,
  output logic [7:0]                      driver_en,
  output port_io_pkg::pad_drive_type      pad
);
  import port_io_pkg::*;
  logic [7:0] pin_val;
  logic [7:0] en;
  logic [7:0] od;
  logic [7:0] norm;

  assign norm = ~special_sel & ~ctrl_ff;
  assign pin_val = (special_sel & special_val) | (~special_sel & ctrl_ff & addr_low)
                 | (norm & logic_use & logic_val) | (norm & ~logic_use & dout_ff);
  assign en = ((special_sel & special_oe) | (~special_sel & (dir_ff | oe_pt))) & VALID;
  assign od = drive_ff & ODM;
  assign driver_en = en;
  // open drain only ever pulls low; a high is left to the pull-up
  assign pad.out = pin_val & ~od;
  assign pad.oe_n = ~(en & ~(od & pin_val));
  assign pad.open_drain = od;
  assign pad.fast_slew = drive_ff & SLEWM;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dout_ff <= REG_RESET;
      dir_ff <= REG_RESET;
      ctrl_ff <= REG_RESET;
      drive_ff <= REG_RESET;
    end else begin
      if (wr_dout) dout_ff <= wdata & VALID;
      if (wr_dir) dir_ff <= wdata & VALID;
      if (wr_ctrl) ctrl_ff <= wdata & VALID & {8{HASC}};
      if (wr_drive) drive_ff <= wdata & VALID & (ODM | SLEWM);
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_dout_store: assert property (wr_dout |=> dout_ff == ($past(wdata) & VALID))
    else $error("data out not stored");
  a_oe_or: assert property ((special_sel == 8'h00)
      |-> driver_en == ((dir_ff | oe_pt) & VALID))
    else $error("enable not direction or term");
  a_od_no_high: assert property ((pad.out & ~pad.oe_n & drive_ff & ODM) == 8'h00)
    else $error("open drain drove high");
  a_addr_out: assert property (((pad.out ^ addr_low) & ctrl_ff & ~special_sel
      & ~(drive_ff & ODM)) == 8'h00)
    else $error("address out mismatch");
endmodule
`default_nettype wire

// ### logic/cell_bank.sv
`default_nettype none
module cell_bank #(
  parameter int GROUPS = 2,
  parameter int GW     = 8
) (
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  input  wire logic [GROUPS-1:0]      wr_cells,
  input  wire logic [GROUPS-1:0]      wr_mask,
  input  wire logic [GW-1:0]          wdata,
  input  wire logic [GROUPS*GW-1:0]   cell_d,
  input  wire logic [GROUPS*GW-1:0]   cell_upd,
  output logic [GROUPS*GW-1:0]        cells_ff,
  output logic [GROUPS*GW-1:0]        mask_ff
);
  import port_io_pkg::*;
  logic [GROUPS*GW-1:0] nxt_cells;
  logic [GROUPS*GW-1:0] mcu_ld;

  for (genvar g = 0; g < GROUPS; g++) begin : grp
    assign mcu_ld[g*GW +: GW] = {GW{wr_cells[g]}} & ~mask_ff[g*GW +: GW];
    // a software load beats the array's own update in the same cycle
    assign nxt_cells[g*GW +: GW] = (mcu_ld[g*GW +: GW] & wdata)
      | (~mcu_ld[g*GW +: GW] & cell_upd[g*GW +: GW] & cell_d[g*GW +: GW])
      | (~mcu_ld[g*GW +: GW] & ~cell_upd[g*GW +: GW] & cells_ff[g*GW +: GW]);
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        mask_ff[g*GW +: GW] <= '0;
        cells_ff[g*GW +: GW] <= '0;
      end else begin
        cells_ff[g*GW +: GW] <= nxt_cells[g*GW +: GW];
        if (wr_mask[g]) mask_ff[g*GW +: GW] <= wdata;
      end
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_cell_load: assert property ((wr_cells[0] && mask_ff[GW-1:0] == '0)
      |=> cells_ff[GW-1:0] == $past(wdata))
    else $error("unmasked cell not loaded");
  a_mask_guard: assert property ((wr_cells[1] && cell_upd[2*GW-1:GW] == '0)
      |=> (cells_ff[2*GW-1:GW] & $past(mask_ff[2*GW-1:GW]))
        == ($past(cells_ff[2*GW-1:GW]) & $past(mask_ff[2*GW-1:GW])))
    else $error("masked cell was loaded");
endmodule
`default_nettype wire

// ### logic/port_io_block.sv
`default_nettype none
// Operation
// - data-in read returns present pin levels, unstored
// - data-out holds last write, reads back, drives pin when enabled
// - output-cell read returns cells; write loads unmasked cells
// - mask bit 1 blocks loading its cell; resets to 0
// - input cells store pin inputs, feed logic array, readable
// - enable-state register reports each driver's actual enable
// - first two ports: upper bits open drain, lower bits fast slew
// - third port: all drive bits select open drain, no slew
// - fourth port: only bits 2 and 1 used, selecting fast slew
// - cell, mask and enable registers exist on first three ports only
// - first group to first or second port; second group to second or third
// - only first two ports have control register and address-out mode
// - peripheral mode on first port only, larger package only
// - fourth port pin 1 can be the shared logic clock input
// - fourth port pin 2 high, as select, disables memories and registers
// - fourth port pins can carry the two external select outputs
// - third port pin 4 can show the battery-on indicator
// - pin enable is direction bit OR output-enable term
// - control bit 0 is plain I/O, 1 is address out
// - drive bit 1 gives open drain or fast slew; 0 push-pull slow
module port_io_block #(
  parameter bit LARGE_PACKAGE = 1'b1
) (
  input  wire logic                           clk_sys,
  input  wire logic                           rst_n,
  input  wire logic                           io_sel,
  input  wire port_io_pkg::mcu_req_type       mcu_req,
  output logic [7:0]                          rdata_ff,
  output logic                                rd_valid_ff,
  input  wire logic [3:0][7:0]                pad_in,
  output port_io_pkg::pad_drive_type [3:0]    pad,
  input  wire port_io_pkg::pld_pin_type [3:0] pld_pin,
  input  wire logic [15:0]                    cell_d,
  input  wire logic [15:0]                    cell_upd,
  output logic [15:0]                         cell_q,
  input  wire logic                           first_to_b,
  input  wire logic                           second_to_c,
  input  wire logic [2:0]                     imc_capture,
  output logic [2:0][7:0]                     logic_input_cells,
  output logic [7:0]                          pld_port_d_in,
  input  wire logic [1:0]                     external_select_outputs,
  input  wire logic                           periph_mode,
  input  wire logic [7:0]                     periph_out,
  input  wire logic [7:0]                     periph_oe,
  input  wire logic [7:0]                     addr_low,
  input  wire logic                           clock_pin_cfg,
  input  wire logic                           select_pin_cfg,
  input  wire logic                           battery_pin_cfg,
  input  wire logic                           supply_below_battery,
  output logic                                shared_logic_clock_input,
  output logic                                module_select_off,
  output logic                                battery_on_indicator
);
  import port_io_pkg::*;

  logic [1:0]       port_idx;
  logic [3:0]       ofs;
  logic             acc_ok;
  logic             rd_ok;
  logic             wr_ok;
  logic [7:0]       nxt_rdata;
  logic [3:0][7:0]  view;
  logic [3:0][7:0]  dout;
  logic [3:0][7:0]  dir;
  logic [3:0][7:0]  ctrl;
  logic [3:0][7:0]  drive;
  logic [3:0][7:0]  driver_en;
  logic [3:0][7:0]  logic_val;
  logic [3:0][7:0]  logic_use;
  logic [3:0][7:0]  sp_sel;
  logic [3:0][7:0]  sp_val;
  logic [3:0][7:0]  sp_oe;
  logic [2:0][7:0]  imc_ff;
  logic [2:0][7:0]  cells_view;
  logic [2:0][7:0]  mask_view;
  logic [15:0]      cells;
  logic [15:0]      mask;
  logic [1:0]       wr_cells;
  logic [1:0]       wr_mask;
  logic             b_first;

  function automatic logic reg_hit(input logic [5:0] a, input logic [1:0] p,
                                   input logic [3:0] o);
    reg_hit = (a[5:4] == p) && (a[3:0] == o);
  endfunction

  // chip select from the pin shuts out register traffic entirely
  assign module_select_off = select_pin_cfg & pad_in[PORT_D][SELECT_PIN_BIT];
  assign acc_ok = io_sel & ~module_select_off;
  assign rd_ok = mcu_req.rd & acc_ok;
  assign wr_ok = mcu_req.wr & acc_ok;
  assign port_idx = mcu_req.addr[5:4];
  assign ofs = mcu_req.addr[3:0];

  assign shared_logic_clock_input = clock_pin_cfg & pad_in[PORT_D][CLOCK_PIN_BIT];
  assign battery_on_indicator = supply_below_battery;
  assign pld_port_d_in = pad_in[PORT_D] & PORT_VALID[PORT_D];

  // group routing; if both groups aim at the second port the first wins
  assign b_first = first_to_b;
  assign logic_val[PORT_A] = cells[7:0];
  assign logic_val[PORT_B] = b_first ? cells[7:0] : cells[15:8];
  assign logic_val[PORT_C] = cells[15:8];
  assign logic_val[PORT_D] = {5'h00, external_select_outputs, 1'b0};
  assign logic_use[PORT_A] = pld_pin[PORT_A].use_logic & {8{~first_to_b}};
  assign logic_use[PORT_B] = pld_pin[PORT_B].use_logic & {8{first_to_b | ~second_to_c}};
  assign logic_use[PORT_C] = pld_pin[PORT_C].use_logic & {8{second_to_c}};
  assign logic_use[PORT_D] = pld_pin[PORT_D].use_logic;

  // peripheral mode hands the first port's pins to the bus path
  assign sp_sel[PORT_A] = {8{periph_mode & LARGE_PACKAGE}};
  assign sp_val[PORT_A] = periph_out;
  assign sp_oe[PORT_A] = periph_oe;
  assign sp_sel[PORT_B] = REG_RESET;
  assign sp_val[PORT_B] = REG_RESET;
  assign sp_oe[PORT_B] = REG_RESET;
  assign sp_sel[PORT_C] = {3'h0, battery_pin_cfg, 4'h0};
  assign sp_val[PORT_C] = {8{supply_below_battery}};
  assign sp_oe[PORT_C] = ALL_PINS;
  assign sp_sel[PORT_D] = REG_RESET;
  assign sp_val[PORT_D] = REG_RESET;
  assign sp_oe[PORT_D] = REG_RESET;

  assign wr_cells[0] = wr_ok & (reg_hit(mcu_req.addr, PORT_A, OFS_OUTPUT_CELLS)
                     | (reg_hit(mcu_req.addr, PORT_B, OFS_OUTPUT_CELLS) & b_first));
  assign wr_cells[1] = wr_ok & (reg_hit(mcu_req.addr, PORT_C, OFS_OUTPUT_CELLS)
                     | (reg_hit(mcu_req.addr, PORT_B, OFS_OUTPUT_CELLS) & ~b_first));
  assign wr_mask[0] = wr_ok & (reg_hit(mcu_req.addr, PORT_A, OFS_LOAD_BLOCK)
                    | (reg_hit(mcu_req.addr, PORT_B, OFS_LOAD_BLOCK) & b_first));
  assign wr_mask[1] = wr_ok & (reg_hit(mcu_req.addr, PORT_C, OFS_LOAD_BLOCK)
                    | (reg_hit(mcu_req.addr, PORT_B, OFS_LOAD_BLOCK) & ~b_first));
  assign cells_view[PORT_A] = cells[7:0];
  assign cells_view[PORT_B] = b_first ? cells[7:0] : cells[15:8];
  assign cells_view[PORT_C] = cells[15:8];
  assign mask_view[PORT_A] = mask[7:0];
  assign mask_view[PORT_B] = b_first ? mask[7:0] : mask[15:8];
  assign mask_view[PORT_C] = mask[15:8];
  assign cell_q = cells;

  cell_bank #(
    .GROUPS (2),
    .GW     (PORT_W)
  ) u_cells (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .wr_cells (wr_cells),
    .wr_mask  (wr_mask),
    .wdata    (mcu_req.wdata),
    .cell_d   (cell_d),
    .cell_upd (cell_upd),
    .cells_ff (cells),
    .mask_ff  (mask)
  );

  for (genvar p = 0; p < NUM_PORTS; p++) begin : lane
    localparam logic [1:0] PI = 2'(p);
    // the fourth port has no cells; its index is folded to 0 and never selected
    localparam int         CI = (p < 3) ? p : 0;
    logic has_cells;
    assign has_cells = (PI != PORT_D);
    // pin levels are passed straight through, never stored
    assign view[p] =
        (ofs == OFS_DATA_IN)      ? pad_in[p] & PORT_VALID[p] :
        (ofs == OFS_DATA_OUT)     ? dout[p] :
        (ofs == OFS_CONTROL)      ? ctrl[p] :
        (ofs == OFS_DIRECTION)    ? dir[p] :
        (ofs == OFS_DRIVE)        ? drive[p] :
        !has_cells                ? REG_RESET :
        (ofs == OFS_INPUT_CELLS)  ? imc_ff[CI] :
        (ofs == OFS_ENABLE_STATE) ? driver_en[p] :
        (ofs == OFS_OUTPUT_CELLS) ? cells_view[CI] :
        (ofs == OFS_LOAD_BLOCK)   ? mask_view[CI] : REG_RESET;

    port_lane #(
      .VALID (PORT_VALID[p]),
      .ODM   (OD_MASK[p]),
      .SLEWM (SLEW_MASK[p]),
      .HASC  (HAS_CONTROL[p])
    ) u_lane (
      .clk_sys     (clk_sys),
      .rst_n       (rst_n),
      .wr_dout     (wr_ok & reg_hit(mcu_req.addr, PI, OFS_DATA_OUT)),
      .wr_dir      (wr_ok & reg_hit(mcu_req.addr, PI, OFS_DIRECTION)),
      .wr_ctrl     (wr_ok & reg_hit(mcu_req.addr, PI, OFS_CONTROL)),
      .wr_drive    (wr_ok & reg_hit(mcu_req.addr, PI, OFS_DRIVE)),
      .wdata       (mcu_req.wdata),
      .addr_low    (addr_low),
      .logic_val   (logic_val[p]),
      .logic_use   (logic_use[p]),
      .oe_pt       (pld_pin[p].oe_pt),
      .special_sel (sp_sel[p]),
      .special_val (sp_val[p]),
      .special_oe  (sp_oe[p]),
      .dout_ff     (dout[p]),
      .dir_ff      (dir[p]),
      .ctrl_ff     (ctrl[p]),
      .drive_ff    (drive[p]),
      .driver_en   (driver_en[p]),
      .pad         (pad[p])
    );
  end

  for (genvar p = 0; p < 3; p++) begin : logic_input_cell
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        imc_ff[p] <= REG_RESET;
      end else if (imc_capture[p]) begin
        imc_ff[p] <= pad_in[p];
      end
    end
  end
  assign logic_input_cells = imc_ff;

  assign nxt_rdata = view[port_idx];

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= REG_RESET;
      rd_valid_ff <= 1'b0;
    end else begin
      rd_valid_ff <= rd_ok;
      if (rd_ok) rdata_ff <= nxt_rdata;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_rd(logic [1:0] p, logic [3:0] o);
    mcu_req.rd && acc_ok && reg_hit(mcu_req.addr, p, o);
  endsequence
  sequence s_wr(logic [1:0] p, logic [3:0] o);
    mcu_req.wr && acc_ok && reg_hit(mcu_req.addr, p, o);
  endsequence

  a_din_direct: assert property (s_rd(PORT_A, OFS_DATA_IN)
      |=> rd_valid_ff && rdata_ff == $past(pad_in[0]))
    else $error("data in not the pin level");
  a_dout_back: assert property ((s_wr(PORT_B, OFS_DATA_OUT) ##1 s_rd(PORT_B, OFS_DATA_OUT))
      |=> rdata_ff == $past(mcu_req.wdata, 2))
    else $error("data out read back wrong");
  a_input_cell: assert property (imc_capture[1]
      |=> logic_input_cells[1] == $past(pad_in[1]))
    else $error("input cell not captured");
  a_enable_view: assert property (s_rd(PORT_B, OFS_ENABLE_STATE)
      |=> rdata_ff == $past(driver_en[1]))
    else $error("enable state wrong");
  a_port_d_bits: assert property (s_rd(PORT_D, OFS_DATA_OUT)
      |=> (rdata_ff & ~PORT_VALID[3]) == 8'h00)
    else $error("unused port bits read set");
  a_d_no_cells: assert property (s_rd(PORT_D, OFS_INPUT_CELLS)
      |=> rdata_ff == 8'h00)
    else $error("fourth port shows input cells");
  a_no_control_c: assert property (s_rd(PORT_C, OFS_CONTROL)
      |=> rdata_ff == 8'h00)
    else $error("third port has control");
  a_select_off: assert property ((module_select_off && mcu_req.rd)
      |=> !rd_valid_ff && $stable(rdata_ff))
    else $error("access while deselected");
  a_battery_pin: assert property ((battery_pin_cfg && !drive[2][4])
      |-> pad[2].out[4] == supply_below_battery && !pad[2].oe_n[4])
    else $error("battery indicator not on pin");
  a_route_first: assert property ((!first_to_b && pld_pin[0].use_logic[0]
      && !sp_sel[0][0] && !ctrl[0][0] && !drive[0][4])
      |-> pad[0].out[0] == cells[0])
    else $error("first group not on first port");
endmodule
`default_nettype wire

// ### tb/pin_world.sv
`default_nettype none
module pin_world (
  input  wire port_io_pkg::pad_drive_type [3:0] pad,
  input  wire logic [3:0][7:0]                  ext,
  output logic [3:0][7:0]                       pad_in
);
  timeunit 1ns;
  timeprecision 1ns;
  import port_io_pkg::*;
  // released pins fall back to the board level, never hold the last driven value
  always_comb begin
    for (int p = 0; p < 4; p++) begin
      pad_in[p] = (pad[p].out & ~pad[p].oe_n) | (ext[p] & pad[p].oe_n);
    end
  end
endmodule
`default_nettype wire

// ### tb/tb_io_port_data_and_drive.sv
`default_nettype none
module tb_io_port_data_and_drive;
  timeunit 1ns;
  timeprecision 1ns;
  import port_io_pkg::*;
  logic                     clk_sys;
  logic                     rst_n;
  logic                     io_sel;
  mcu_req_type              mcu_req;
  logic [7:0]               rdata_ff;
  logic                     rd_valid_ff;
  logic [3:0][7:0]          pad_in;
  logic [3:0][7:0]          ext;
  pad_drive_type [3:0]      pad;
  pld_pin_type [3:0]        pld_pin;
  logic [15:0]              cell_q;
  logic                     first_to_b;
  logic                     second_to_c;
  logic [2:0]               imc_capture;
  logic [2:0][7:0]          imc_q;
  logic [7:0]               pld_port_d_in;
  logic [1:0]               ext_sel;
  logic [7:0]               addr_low;
  logic [3:0]               cfg;
  logic                     clk_in;
  logic                     sel_off;
  logic                     bat_on;
  int                       err_count;
  int                       comparisons;
  int                       cycles;
  logic [3:0][7:0]          od_exp;
  logic [3:0][7:0]          slew_exp;

  port_io_block dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .io_sel(io_sel), .mcu_req(mcu_req),
    .rdata_ff(rdata_ff), .rd_valid_ff(rd_valid_ff), .pad_in(pad_in), .pad(pad),
    .pld_pin(pld_pin), .cell_d(16'h0000), .cell_upd(16'h0000), .cell_q(cell_q),
    .first_to_b(first_to_b), .second_to_c(second_to_c), .imc_capture(imc_capture),
    .logic_input_cells(imc_q), .pld_port_d_in(pld_port_d_in),
    .external_select_outputs(ext_sel), .periph_mode(1'b0), .periph_out(8'h00),
    .periph_oe(8'h00), .addr_low(addr_low), .clock_pin_cfg(cfg[0]),
    .select_pin_cfg(cfg[1]), .battery_pin_cfg(cfg[2]), .supply_below_battery(cfg[3]),
    .shared_logic_clock_input(clk_in), .module_select_off(sel_off),
    .battery_on_indicator(bat_on)
  );
  pin_world partner (.pad(pad), .ext(ext), .pad_in(pad_in));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one request cycle, released at the edge that takes it
  task automatic acc(input logic r, input logic w, input logic [1:0] p,
                     input logic [3:0] o, input logic [7:0] d, input logic s);
    @(posedge clk_sys);
    mcu_req <= '{rd: r, wr: w, addr: {p, o}, wdata: d};
    io_sel  <= s;
    @(posedge clk_sys);
    mcu_req.rd <= 1'b0;
    mcu_req.wr <= 1'b0;
    io_sel     <= 1'b0;
  endtask

  task automatic wr(input logic [1:0] p, input logic [3:0] o, input logic [7:0] d);
    acc(1'b0, 1'b1, p, o, d, 1'b1);
  endtask

  task automatic rd(input logic [1:0] p, input logic [3:0] o, input logic [7:0] e);
    acc(1'b1, 1'b0, p, o, 8'h00, 1'b1);
    #1;
    chk({7'h00, rd_valid_ff}, 8'h01);
    chk(rdata_ff, e);
  endtask

  task automatic t_reset;
    rd(PORT_A, OFS_DATA_OUT, 8'h00);
    rd(PORT_B, OFS_LOAD_BLOCK, 8'h00);
    rd(PORT_B, OFS_DRIVE, 8'h00);
    rd(PORT_A, 4'hf, 8'h00);
  endtask

  task automatic t_data;
    ext[1] <= 8'h33;
    wr(PORT_B, OFS_DATA_OUT, 8'h5a);
    wr(PORT_B, OFS_DIRECTION, 8'h0f);
    rd(PORT_B, OFS_DATA_OUT, 8'h5a);
    rd(PORT_B, OFS_DATA_IN, 8'h3a);
    rd(PORT_B, OFS_ENABLE_STATE, 8'h0f);
    chk(pad[1].oe_n, 8'hf0);
    pld_pin[1].oe_pt <= 8'h30;
    rd(PORT_B, OFS_ENABLE_STATE, 8'h3f);
    rd(PORT_B, OFS_DATA_IN, 8'h1a);
  endtask

  task automatic t_cells;
    wr(PORT_A, OFS_LOAD_BLOCK, 8'h0f);
    wr(PORT_A, OFS_OUTPUT_CELLS, 8'hff);
    rd(PORT_A, OFS_OUTPUT_CELLS, 8'hf0);
    chk(cell_q[7:0], 8'hf0);
    second_to_c <= 1'b1;
    wr(PORT_C, OFS_OUTPUT_CELLS, 8'h3c);
    rd(PORT_C, OFS_OUTPUT_CELLS, 8'h3c);
    chk(cell_q[15:8], 8'h3c);
    wr(PORT_D, OFS_LOAD_BLOCK, 8'hff);
    rd(PORT_D, OFS_LOAD_BLOCK, 8'h00);
    rd(PORT_D, OFS_OUTPUT_CELLS, 8'h00);
    rd(PORT_D, OFS_ENABLE_STATE, 8'h00);
  endtask

  task automatic t_drive;
    od_exp   = {8'h00, 8'hff, 8'hf0, 8'hf0};
    slew_exp = {8'h06, 8'h00, 8'h0f, 8'h0f};
    for (int p = 0; p < 4; p++) begin
      wr(p[1:0], OFS_DRIVE, 8'hff);
      rd(p[1:0], OFS_DRIVE, od_exp[p] | slew_exp[p]);
      chk(pad[p].open_drain, od_exp[p]);
      chk(pad[p].fast_slew, slew_exp[p]);
      wr(p[1:0], OFS_DRIVE, 8'h00);
    end
  endtask

  task automatic t_ctrl;
    addr_low <= 8'h3c;
    wr(PORT_A, OFS_DIRECTION, 8'hff);
    wr(PORT_A, OFS_CONTROL, 8'hf0);
    #1;
    chk(pad[0].out, 8'h30);
    wr(PORT_C, OFS_CONTROL, 8'hff);
    rd(PORT_C, OFS_CONTROL, 8'h00);
    acc(1'b0, 1'b1, PORT_A, OFS_DATA_OUT, 8'h77, 1'b0);
    rd(PORT_A, OFS_DATA_OUT, 8'h00);
  endtask

  task automatic t_inputs;
    ext[2] <= 8'ha5;
    @(posedge clk_sys);
    imc_capture <= 3'h4;
    @(posedge clk_sys);
    imc_capture <= 3'h0;
    ext[2] <= 8'h00;
    #1;
    chk(imc_q[2], 8'ha5);
    rd(PORT_C, OFS_INPUT_CELLS, 8'ha5);
  endtask

  task automatic t_port_d;
    ext[3] <= 8'hff;
    cfg    <= 4'hf;
    #1;
    @(posedge clk_sys);
    #1;
    chk(pld_port_d_in, 8'h06);
    chk({5'h00, clk_in, sel_off, bat_on}, 8'h07);
    acc(1'b1, 1'b0, PORT_A, OFS_DATA_OUT, 8'h00, 1'b1);
    #1;
    chk({7'h00, rd_valid_ff}, 8'h00);
    ext[3] <= 8'h00;
    cfg    <= 4'h0;
    pld_pin[3].use_logic <= 8'h06;
    ext_sel <= 2'b01;
    wr(PORT_D, OFS_DIRECTION, 8'h06);
    #1;
    chk({6'h00, pad[3].out[2:1]}, 8'h01);
    chk({5'h00, clk_in, sel_off, bat_on}, 8'h00);
  endtask

  task automatic results;
    if (err_count == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // a hung handshake is cut off well past the hundred or so cycles the run needs
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_count++;
      results();
    end
  end

  initial begin
    err_count = 0;
    comparisons = 0;
    cycles = 0;
    rst_n = 1'b0;
    io_sel = 1'b0;
    mcu_req = '0;
    ext = '0;
    pld_pin = '0;
    first_to_b = 1'b0;
    second_to_c = 1'b0;
    imc_capture = 3'h0;
    ext_sel = 2'b00;
    addr_low = 8'h00;
    cfg = 4'h0;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset();
    t_data();
    t_cells();
    t_drive();
    t_ctrl();
    t_inputs();
    t_port_d();
    results();
  end
endmodule
`default_nettype wire
